/* File: src/twbfb_defs.svh */
// Register offsets, field positions and timing counts of the two-wire flag block
`ifndef TWBFB_DEFS_SVH
`define TWBFB_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TWBFB_OFS_CTRL 8'h00
`define TWBFB_OFS_STATUS 8'h04
`define TWBFB_OFS_MASK 8'h08
`define TWBFB_OFS_CMD 8'h0C
`define TWBFB_OFS_OWNADDR 8'h10
`define TWBFB_OFS_DATA 8'h14
`define TWBFB_OFS_SECOND_LO 8'h40
`define TWBFB_OFS_SECOND_HI 8'h5F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TWBFB_CTRL_EN 0
`define TWBFB_CTRL_TO_EN 1
`define TWBFB_CTRL_SDAH 4
`define TWBFB_ST_STOP_ADDRESS_IRQ_FLAG 0
`define TWBFB_ST_DIF 1
`define TWBFB_ST_COLL 2
`define TWBFB_ST_TOF 3
`define TWBFB_ST_HOLD 4
`define TWBFB_ST_BUSY 5
`define TWBFB_ST_RW 6
`define TWBFB_CMD_RESP 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TWBFB_CLK_PERIOD_NS 4
`define TWBFB_TIMEOUT_NS 50000
`define TWBFB_TIMEOUT_CYC (`TWBFB_TIMEOUT_NS / `TWBFB_CLK_PERIOD_NS)
`define TWBFB_SDA_HOLD_NS 300
`define TWBFB_SDA_HOLD_CYC ((`TWBFB_SDA_HOLD_NS + `TWBFB_CLK_PERIOD_NS - 1) / `TWBFB_CLK_PERIOD_NS)

`endif

/* File: src/twbfb_pkg.sv */
// Types of the two-wire flag block
`default_nettype none

package twbfb_pkg;
    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_ADDR = 3'h1,
        PH_RX = 3'h2,
        PH_ACK = 3'h3,
        PH_TX = 3'h4,
        PH_TXACK = 3'h5,
        PH_SKIP = 3'h6
    } twbfb_phase_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic ctrl_en;
        logic ctrl_to_en;
        logic ctrl_sdah;
        logic [6:0] own_addr;
        logic [3:0] mask;
        logic stop_address_irq_flag;
        logic slave_data_irq_flag;
        logic coll;
        logic tof;
        logic hold;
        logic dif_clr_pend;
        logic bus_busy;
        twbfb_phase_type phase;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic mack;
        logic [7:0] rx_data;
        logic [7:0] tx_data;
        logic scl_prev;
        logic sda_prev;
        logic [15:0] to_cnt;
        logic [7:0] sh_cnt;
        logic sda_low_want;
        logic sda_oe_n;
        logic scl_oe_n;
        logic irq;
    } twbfb_state_type;
endpackage

`default_nettype wire

/* File: src/twbfb_sync.sv */
// Two-stage synchroniser for pin inputs
`default_nettype none

module twbfb_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [1:0][WIDTH-1:0] stage_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_q <= {RESET_VAL, RESET_VAL};
        end else begin
            stage_q <= {stage_q[0], din};
        end
    end

    assign dout = stage_q[1];
endmodule // twbfb_sync

`default_nettype wire

/* File: src/twbfb_top.sv */
// Two-wire slave flag logic with AXI4-Lite register access
// Summary of operation
// - A fresh START clears the transmit collision flag, a repeated START leaves it as it was.
// - A stop/address flag clear that meets a hardware set loses; against an address-match set SCL also stays held.
// - A bus timeout in the same cycle as a START drops the transaction that START began.
// - The response command 0b11 clears the data flag one cycle later, so the next read still sees it.
// - Accesses to the absent second instance are ignored like a reserved address.
// - The SDA hold option is a single bit and its upper bit neither stores nor reads.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`include "twbfb_defs.svh"
`default_nettype none

module twbfb_top #(
    parameter logic [15:0] TIMEOUT_CYCLES = 16'(`TWBFB_TIMEOUT_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic irq
);
    localparam logic [7:0] SDA_HOLD_CYC = 8'(`TWBFB_SDA_HOLD_CYC);

    twbfb_pkg::twbfb_state_type st_q, st_d;
    logic [1:0] pins;
    logic scl, sda, scl_rise, scl_fall, start_det, stop_det, to_fire, wr_go, second_hit, resp_cmd;
    logic stop_address_irq_flag_set, stop_address_irq_flag_clr, dif_set, dif_clr, coll_set, coll_clr_sw, coll_clr_hw, tof_set, tof_clr;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    twbfb_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({sda_i, scl_i}),
        .dout(pins)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        scl = pins[0];
        sda = pins[1];
        scl_rise = scl & ~st_q.scl_prev;
        scl_fall = ~scl & st_q.scl_prev;
        start_det = st_q.scl_prev & scl & st_q.sda_prev & ~sda;
        stop_det = st_q.scl_prev & scl & ~st_q.sda_prev & sda;
        to_fire = st_q.ctrl_to_en & st_q.bus_busy & (st_q.to_cnt == TIMEOUT_CYCLES - 16'h0001);
        wr_go = st_q.aw_held & st_q.w_held & ~st_q.bvalid;
        second_hit = wr_go & (st_q.awaddr >= `TWBFB_OFS_SECOND_LO) & (st_q.awaddr <= `TWBFB_OFS_SECOND_HI);
        resp_cmd = 1'h0;
        stop_address_irq_flag_set = 1'h0;
        stop_address_irq_flag_clr = 1'h0;
        dif_set = 1'h0;
        dif_clr = 1'h0;
        coll_set = 1'h0;
        coll_clr_sw = 1'h0;
        coll_clr_hw = 1'h0;
        tof_set = 1'h0;
        tof_clr = 1'h0;
        st_d.scl_prev = scl;
        st_d.sda_prev = sda;

        // Bus slave: write side
        if (s_axil_awvalid && st_q.awready) begin
            st_d.aw_held = 1'h1;
            st_d.awaddr = s_axil_awaddr;
        end
        if (s_axil_wvalid && st_q.wready) begin
            st_d.w_held = 1'h1;
            st_d.wdata = s_axil_wdata;
            st_d.wstrb = s_axil_wstrb;
        end
        if (st_q.bvalid && s_axil_bready) begin
            st_d.bvalid = 1'h0;
        end
        if (wr_go) begin
            st_d.bvalid = 1'h1;
            st_d.aw_held = 1'h0;
            st_d.w_held = 1'h0;
            if (second_hit || !st_q.wstrb[0]) begin
                // Absent instance and unmapped lanes: accepted, nothing stored
                st_d.bvalid = 1'h1;
            end else begin
                case (st_q.awaddr)
                    `TWBFB_OFS_CTRL: begin
                        st_d.ctrl_en = st_q.wdata[`TWBFB_CTRL_EN];
                        st_d.ctrl_to_en = st_q.wdata[`TWBFB_CTRL_TO_EN];
                        st_d.ctrl_sdah = st_q.wdata[`TWBFB_CTRL_SDAH];
                    end
                    `TWBFB_OFS_STATUS: begin
                        stop_address_irq_flag_clr = st_q.wdata[`TWBFB_ST_STOP_ADDRESS_IRQ_FLAG];
                        dif_clr = st_q.wdata[`TWBFB_ST_DIF];
                        coll_clr_sw = st_q.wdata[`TWBFB_ST_COLL];
                        tof_clr = st_q.wdata[`TWBFB_ST_TOF];
                    end
                    `TWBFB_OFS_MASK: st_d.mask = st_q.wdata[3:0];
                    `TWBFB_OFS_CMD: resp_cmd = (st_q.wdata[1:0] == `TWBFB_CMD_RESP);
                    `TWBFB_OFS_OWNADDR: st_d.own_addr = st_q.wdata[6:0];
                    `TWBFB_OFS_DATA: st_d.tx_data = st_q.wdata[7:0];
                    default: st_d.bvalid = 1'h1;
                endcase
            end
        end
        // Software release of the clock hold; a hardware set below overrides it
        if ((stop_address_irq_flag_clr && st_q.stop_address_irq_flag) || resp_cmd) begin
            st_d.hold = 1'h0;
        end

        // Bus slave: read side
        if (st_q.rvalid && s_axil_rready) begin
            st_d.rvalid = 1'h0;
        end
        if (s_axil_arvalid && st_q.arready) begin
            st_d.rvalid = 1'h1;
            case (s_axil_araddr)
                `TWBFB_OFS_CTRL: st_d.rdata = {27'h0, st_q.ctrl_sdah, 2'h0, st_q.ctrl_to_en, st_q.ctrl_en};
                `TWBFB_OFS_STATUS: st_d.rdata = {25'h0, st_q.rw, st_q.bus_busy, st_q.hold,
                                                 st_q.tof, st_q.coll, st_q.slave_data_irq_flag, st_q.stop_address_irq_flag};
                `TWBFB_OFS_MASK: st_d.rdata = {28'h0, st_q.mask};
                `TWBFB_OFS_OWNADDR: st_d.rdata = {25'h0, st_q.own_addr};
                `TWBFB_OFS_DATA: st_d.rdata = {24'h0, st_q.rx_data};
                default: st_d.rdata = 32'h0;
            endcase
        end

        // Bus timeout counter
        if (!st_q.bus_busy || scl_rise || scl_fall || to_fire) begin
            st_d.to_cnt = 16'h0;
        end else begin
            st_d.to_cnt = st_q.to_cnt + 16'h0001;
        end

        // Bit engine
        if (to_fire) begin
            // A START seen together with the timeout is dropped here
            tof_set = 1'h1;
            st_d.bus_busy = 1'h0;
            st_d.phase = twbfb_pkg::PH_IDLE;
            st_d.hold = 1'h0;
            st_d.sda_low_want = 1'h0;
        end else if (stop_det) begin
            stop_address_irq_flag_set = st_q.phase != twbfb_pkg::PH_SKIP && st_q.phase != twbfb_pkg::PH_IDLE;
            st_d.bus_busy = 1'h0;
            st_d.phase = twbfb_pkg::PH_IDLE;
            st_d.sda_low_want = 1'h0;
        end else if (start_det) begin
            coll_clr_hw = ~st_q.bus_busy;
            st_d.bus_busy = 1'h1;
            st_d.phase = twbfb_pkg::PH_ADDR;
            st_d.bitcnt = 4'h0;
            st_d.hold = 1'h0;
            st_d.sda_low_want = 1'h0;
        end else begin
            case (st_q.phase)
                twbfb_pkg::PH_ADDR, twbfb_pkg::PH_RX: begin
                    if (scl_rise) begin
                        st_d.shreg = {st_q.shreg[6:0], sda};
                        st_d.bitcnt = st_q.bitcnt + 4'h1;
                    end
                    if (scl_fall && st_q.bitcnt == 4'h8) begin
                        st_d.bitcnt = 4'h0;
                        if (st_q.phase == twbfb_pkg::PH_RX) begin
                            st_d.rx_data = st_q.shreg;
                            dif_set = 1'h1;
                            st_d.hold = 1'h1;
                            st_d.sda_low_want = 1'h1;
                            st_d.phase = twbfb_pkg::PH_ACK;
                        end else if (st_q.ctrl_en && st_q.shreg[7:1] == st_q.own_addr) begin
                            stop_address_irq_flag_set = 1'h1;
                            st_d.rw = st_q.shreg[0];
                            st_d.hold = 1'h1;
                            st_d.sda_low_want = 1'h1;
                            st_d.phase = twbfb_pkg::PH_ACK;
                        end else begin
                            st_d.phase = twbfb_pkg::PH_SKIP;
                        end
                    end
                end
                twbfb_pkg::PH_ACK: begin
                    if (scl_fall) begin
                        st_d.bitcnt = 4'h0;
                        if (st_q.rw) begin
                            st_d.shreg = st_q.tx_data;
                            st_d.sda_low_want = ~st_q.tx_data[7];
                            st_d.phase = twbfb_pkg::PH_TX;
                        end else begin
                            st_d.sda_low_want = 1'h0;
                            st_d.phase = twbfb_pkg::PH_RX;
                        end
                    end
                end
                twbfb_pkg::PH_TX: begin
                    if (scl_rise) begin
                        coll_set = ~st_q.sda_low_want & st_q.sda_oe_n & ~sda;
                        st_d.bitcnt = st_q.bitcnt + 4'h1;
                    end
                    if (scl_fall) begin
                        if (st_q.bitcnt == 4'h8) begin
                            st_d.sda_low_want = 1'h0;
                            st_d.phase = twbfb_pkg::PH_TXACK;
                        end else begin
                            st_d.shreg = {st_q.shreg[6:0], 1'h0};
                            st_d.sda_low_want = ~st_q.shreg[6];
                        end
                    end
                end
                twbfb_pkg::PH_TXACK: begin
                    if (scl_rise) begin
                        st_d.mack = ~sda;
                    end
                    if (scl_fall) begin
                        if (st_q.mack) begin
                            dif_set = 1'h1;
                            st_d.hold = 1'h1;
                            st_d.phase = twbfb_pkg::PH_ACK;
                        end else begin
                            st_d.phase = twbfb_pkg::PH_SKIP;
                        end
                    end
                end
                twbfb_pkg::PH_IDLE, twbfb_pkg::PH_SKIP: st_d.phase = st_q.phase;
                default: st_d.phase = twbfb_pkg::PH_IDLE;
            endcase
        end

        // Sticky flags: a hardware set wins over any clear
        st_d.stop_address_irq_flag = stop_address_irq_flag_set | (st_q.stop_address_irq_flag & ~stop_address_irq_flag_clr);
        st_d.coll = coll_set | (st_q.coll & ~(coll_clr_sw | coll_clr_hw));
        st_d.dif_clr_pend = resp_cmd;
        st_d.slave_data_irq_flag = dif_set | (st_q.slave_data_irq_flag & ~(dif_clr | st_q.dif_clr_pend));
        st_d.tof = tof_set | (st_q.tof & ~tof_clr);

        // SDA hold delay after SCL falls
        if (scl_fall) begin
            st_d.sh_cnt = 8'h0;
        end else if (st_q.sh_cnt != SDA_HOLD_CYC) begin
            st_d.sh_cnt = st_q.sh_cnt + 8'h01;
        end
        if (!st_q.ctrl_sdah || st_d.sh_cnt == SDA_HOLD_CYC) begin
            st_d.sda_oe_n = ~st_d.sda_low_want;
        end
        st_d.scl_oe_n = ~st_d.hold;
        st_d.irq = |({st_d.tof, st_d.coll, st_d.slave_data_irq_flag, st_d.stop_address_irq_flag} & st_d.mask);
        st_d.awready = ~st_d.aw_held & ~st_d.bvalid;
        st_d.wready = ~st_d.w_held & ~st_d.bvalid;
        st_d.arready = ~st_d.rvalid;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.scl_prev <= 1'h1;
            st_q.sda_prev <= 1'h1;
            st_q.sda_oe_n <= 1'h1;
            st_q.scl_oe_n <= 1'h1;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axil_awready = st_q.awready;
    assign s_axil_wready = st_q.wready;
    assign s_axil_bvalid = st_q.bvalid;
    assign s_axil_bresp = st_q.rdata[31:30] & 2'h0;
    assign s_axil_arready = st_q.arready;
    assign s_axil_rvalid = st_q.rvalid;
    assign s_axil_rdata = st_q.rdata;
    assign s_axil_rresp = st_q.rdata[31:30] & 2'h0;
    assign scl_o = st_q.shreg[0] & 1'h0;
    assign sda_o = st_q.shreg[0] & 1'h0;
    assign scl_oe_n = st_q.scl_oe_n;
    assign sda_oe_n = st_q.sda_oe_n;
    assign irq = st_q.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_coll_start_clear: assert property (start_det && !st_q.bus_busy && !to_fire |=> !st_q.coll)
        else $error("collision flag not cleared by fresh start");
    a_coll_rep_keep: assert property (start_det && st_q.bus_busy && !to_fire && !coll_clr_sw
        |=> st_q.coll == $past(st_q.coll))
        else $error("collision flag changed on repeated start");
    a_stop_address_irq_flag_race_hold: assert property (stop_address_irq_flag_set && stop_address_irq_flag_clr |=> st_q.stop_address_irq_flag && st_q.hold ##1 !scl_oe_n)
        else $error("clear won over address set");
    a_to_start_drop: assert property (to_fire && start_det |=> st_q.phase == twbfb_pkg::PH_IDLE
        && !st_q.bus_busy && st_q.tof)
        else $error("start at timeout not dropped");
    a_dif_late_clear: assert property (resp_cmd && st_q.slave_data_irq_flag && !dif_clr |=> st_q.slave_data_irq_flag ##1 !st_q.slave_data_irq_flag)
        else $error("data flag cleared at wrong cycle");
    a_second_ignored: assert property (second_hit |=> {st_q.ctrl_en, st_q.ctrl_to_en, st_q.ctrl_sdah,
        st_q.mask, st_q.own_addr, st_q.tx_data} == $past({st_q.ctrl_en, st_q.ctrl_to_en,
        st_q.ctrl_sdah, st_q.mask, st_q.own_addr, st_q.tx_data}))
        else $error("second instance write took effect");
    a_sda_hold_one: assert property (s_axil_arvalid && s_axil_arready && s_axil_araddr == `TWBFB_OFS_CTRL
        |=> s_axil_rvalid && s_axil_rdata[5] == 1'h0)
        else $error("unimplemented hold bit reads set");
    a_stop_flag_edge: assert property (stop_det && !to_fire && st_q.phase == twbfb_pkg::PH_RX
        |=> st_q.stop_address_irq_flag && !st_q.bus_busy)
        else $error("stop flag not set on the next edge");
    a_irq_level: assert property (irq == |({st_q.tof, st_q.coll, st_q.slave_data_irq_flag, st_q.stop_address_irq_flag} & st_q.mask))
        else $error("interrupt output disagrees with flags");

    c_addr_match: cover property (stop_address_irq_flag_set && st_q.phase == twbfb_pkg::PH_ADDR);
    c_stop_address_irq_flag_race: cover property (stop_address_irq_flag_set && stop_address_irq_flag_clr);
    c_to_start: cover property (to_fire && start_det);
    c_dif_resp: cover property (resp_cmd && st_q.slave_data_irq_flag);
endmodule // twbfb_top

`default_nettype wire

/* File: testbench/test_twbfb_top.sv */
// Self-checking bench of the two-wire flag block
`include "twbfb_defs.svh"
`default_nettype none

module test_twbfb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] CT = `TWBFB_OFS_CTRL;
    localparam logic [7:0] ST = `TWBFB_OFS_STATUS;
    localparam logic [7:0] MK = `TWBFB_OFS_MASK;
    localparam logic [7:0] IGN [3] = '{8'h40, 8'h5C, 8'h30};
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, ack;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl_low, m_sda_low, stuck, scl_w, sda_w;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    int err_count, n_checks;

    twbfb_top #(.TIMEOUT_CYCLES(16'h0040)) dut_u (
        .clk(clk), .rst(rst),
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
        .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
        .s_axil_bresp(), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
        .s_axil_rdata(rdata), .s_axil_rresp(), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq)
    );
    twbfb_bus_model mdl_u (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low),
        .stuck(stuck));

    // Open-drain wires with pull-ups
    assign scl_w = (scl_oe_n | scl_o) & ~m_scl_low;
    assign sda_w = (sda_oe_n | sda_o) & ~m_sda_low;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic give_up();
        err_count++;
        test_done();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 1000);
        bready <= 1'b0;
        if (n >= 1000) give_up();
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 1000);
        d = rdata;
        rready <= 1'b0;
        if (n >= 1000) give_up();
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        bus_read(a, rd);
        check(rd & m, exp);
    endtask

    // Polls until SCL is held, checks status, then issues the response command
    task automatic serve(input logic [31:0] exp, input logic race);
        int n;
        n = 0;
        do begin
            bus_read(ST, rd);
            n++;
        end while (!rd[`TWBFB_ST_HOLD] && n < 3000);
        if (n >= 3000) give_up();
        check(rd & 32'h7F, exp);
        if (!race) begin
            bus_write(`TWBFB_OFS_CMD, 32'h3);
        end else begin
            fork
                bus_write(`TWBFB_OFS_CMD, 32'h3);
                begin
                    for (int k = 0; k < 50 && !(awvalid && awready); k++) @(posedge clk);
                    expect_reg(ST, 32'h2, 32'h2);
                end
            join
            expect_reg(ST, 32'h0, 32'h2);
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        give_up();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        err_count = 0;
        n_checks = 0;
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        expect_reg(CT, 32'h0, 32'hFFFFFFFF);
        expect_reg(ST, 32'h0, 32'hFFFFFFFF);
        expect_reg(MK, 32'h0, 32'hFFFFFFFF);
        check({27'h0, scl_o, sda_o, irq, scl_oe_n, sda_oe_n}, 32'h3);
        bus_write(CT, 32'h33);
        expect_reg(CT, 32'h13, 32'hFFFFFFFF);
        for (int i = 0; i < 3; i++) begin
            bus_write(IGN[i], 32'hFF);
            expect_reg(IGN[i], 32'h0, 32'hFFFFFFFF);
        end
        expect_reg(CT, 32'h13, 32'hFFFFFFFF);
        bus_write(CT, 32'h1);
        bus_write(`TWBFB_OFS_OWNADDR, 32'h2A);
        bus_write(MK, 32'h1);
        bus_write(`TWBFB_OFS_DATA, 32'hFF);
        // Write transfer: address, one data byte, stop
        mdl_u.start();
        fork mdl_u.send_byte(8'h54, ack); serve(32'h31, 1'b0); join
        check({31'h0, ack}, 32'h1);
        fork mdl_u.send_byte(8'hA5, ack); serve(32'h33, 1'b1); join
        expect_reg(`TWBFB_OFS_DATA, 32'hA5, 32'hFF);
        mdl_u.stop();
        expect_reg(ST, 32'h01, 32'h3F);
        check({31'h0, irq}, 32'h1);
        bus_write(MK, 32'h0);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        bus_write(MK, 32'h1);
        bus_write(ST, 32'h1);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        // Read transfer with a collision, then a repeated start
        mdl_u.start();
        fork mdl_u.send_byte(8'h55, ack); serve(32'h71, 1'b0); join
        mdl_u.send_byte(8'h00, ack);
        mdl_u.rstart();
        fork mdl_u.send_byte(8'h55, ack); serve(32'h75, 1'b0); join
        mdl_u.send_byte(8'hFF, ack);
        mdl_u.stop();
        expect_reg(ST, 32'h05, 32'h3F);
        bus_write(ST, 32'h1);
        mdl_u.start();
        fork mdl_u.send_byte(8'h55, ack); serve(32'h71, 1'b0); join
        bus_write(ST, 32'h4);
        mdl_u.send_byte(8'hFF, ack);
        mdl_u.stop();
        bus_write(ST, 32'h1);
        // Bus timeout while SCL stands still
        bus_write(CT, 32'h3);
        mdl_u.start();
        repeat (200) @(posedge clk);
        expect_reg(ST, 32'h08, 32'h3F);
        mdl_u.stop();
        bus_write(ST, 32'h8);
        // Timeout in the same cycle as a repeated START
        mdl_u.start();
        mdl_u.rstart_late(64);
        mdl_u.send_byte(8'h54, ack);
        check({31'h0, ack}, 32'h0);
        mdl_u.stop();
        expect_reg(ST, 32'h08, 32'h3F);
        check({31'h0, stuck}, 32'h0);
        test_done();
    end
endmodule // test_twbfb_top

`default_nettype wire

/* File: testbench/twbfb_bus_model.sv */
// Behavioural two-wire bus master on the far side of the flag block
`default_nettype none

module twbfb_bus_model #(
    parameter int HALF = 40
) (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low,
    output logic stuck
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        stuck = 1'b0;
    end

    task automatic gap();
        repeat (HALF) @(posedge clk);
    endtask

    // Releases SCL, waits out a stretch, samples SDA late in the high phase
    task automatic clock_high(output logic smp);
        int n;
        n = 0;
        scl_low <= 1'b0;
        @(posedge clk);
        while (scl !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        stuck <= stuck | (n >= 20000);
        gap();
        smp = sda;
        scl_low <= 1'b1;
        gap();
    endtask

    task automatic start();
        sda_low <= 1'b1;
        gap();
        scl_low <= 1'b1;
        gap();
    endtask

    task automatic rstart();
        sda_low <= 1'b0;
        gap();
        scl_low <= 1'b0;
        gap();
        start();
    endtask

    // Repeated START whose SDA fall lands n cycles after the SCL rise
    task automatic rstart_late(input int n);
        sda_low <= 1'b0;
        scl_low <= 1'b0;
        repeat (n) @(posedge clk);
        sda_low <= 1'b1;
        gap();
        scl_low <= 1'b1;
        gap();
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        gap();
        scl_low <= 1'b0;
        gap();
        sda_low <= 1'b0;
        gap();
    endtask

    // Drives a byte MSB first, then releases SDA and returns 1 for an ACK
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sda_low <= ~b[i];
            gap();
            clock_high(s);
        end
        sda_low <= 1'b0;
        gap();
        clock_high(s);
        ack = ~s;
    endtask
endmodule // twbfb_bus_model

`default_nettype wire
